// [rx_gain_squelch_rssi_control.sv]
// Receive chain filter, gain, squelch, AGC and RSSI control with an Avalon-MM register slave
//
// Behaviour
// - Stage one: six 2.5 dB cuts, boost
// - Stage one gain only by register, resets lowest
// - Low-pass code maps to five corners
// - Shared zero bits set stage zeros
// - Stage two/three: six 3 dB cuts
// - Reset gain command clears squelch, loads manual
// - Five digitizer window settings, 3 dB apart
// - Eleven steps: five window, six gain
// - Start from manual; gain state readable
// - Squelch runs 18.88 us until timer match
// - Squelch ratio bit picks observed comparator
// - Over two edges per 50 us cuts
// - Ratio six observes six-times window comparator
// - AGC only while receive-on high
// - Receive-on fall latches gain state
// - AGC cuts gain while comparator toggles
// - AGC mode: whole frame or eight pulses
// - AGC algorithm: preset or reset start
// - RSSI peak hold, restarts on cut
// - RSSI four bits, capped at Dh
// - Clear command zeroes and restarts RSSI
// - Mask timer keeps receive-on low
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "rx_gain_params.svh"

module rx_gain_squelch_rssi_control #(
  parameter int SQ_WINDOW_CYC = `SQ_WINDOW_CYC,
  parameter int MASK_TIMER_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_on,
  input wire logic [MASK_TIMER_W-1:0] mask_receive_timer,
  input wire rx_gain_pkg::rx_events_t rx_events,
  input wire logic [3:0] rssi_am_level,
  input wire logic [3:0] rssi_pm_level,
  output rx_gain_pkg::rx_ctrl_t rx_ctrl,
  output logic filter_code_unused
);

  logic [7:0] filter_cfg_q;
  logic [7:0] stage1_cfg_q;
  logic [7:0] loop_cfg_q;
  logic [7:0] manual_cfg_q;
  logic [7:0] sq_timer_q;
  logic [3:0] gain_state_q;
  logic [3:0] rssi_am_q;
  logic [3:0] rssi_pm_q;
  logic [3:0] step_q;
  logic [3:0] sq_step_q;
  logic rx_on_q;
  logic [3:0] pulse_cnt_q;
  logic [10:0] sq_delay_q;
  logic [12:0] sq_win_q;
  logic [2:0] sq_edges_q;
  rx_gain_pkg::sq_state_t sq_state_q;
  logic wr_take;
  logic rd_take;
  logic cmd_reset_gain;
  logic clear_signal_strength_command;
  logic rx_rise;
  logic rx_fall;
  logic agc_active;
  logic agc_cut;
  logic sq_edge;
  logic sq_cut;
  logic [3:0] manual_step;
  logic [3:0] start_step;
  logic [3:0] eff_step;
  logic [2:0] s1_wr;

  // Request stands until waitrequest is seen low; that edge commits a write
  assign wr_take = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && avs_waitrequest;
  assign cmd_reset_gain = wr_take && (avs_address == `OFS_COMMAND) && avs_writedata[`CMD_RESET_GAIN];
  assign clear_signal_strength_command = wr_take && (avs_address == `OFS_COMMAND) &&
                                         avs_writedata[`CMD_CLEAR_STRENGTH];
  assign rx_rise = rx_on && !rx_on_q;
  assign rx_fall = !rx_on && rx_on_q;
  // Manual start step saturates at the last step
  assign manual_step = (manual_cfg_q[3:0] > `STEP_MAX) ? `STEP_MAX : manual_cfg_q[3:0];
  // Preset starts at max window, max gain unless the manual start is already past it
  assign start_step = (loop_cfg_q[`LC_AGC_ALG] && manual_step < `STEP_WIN_MAX) ? `STEP_WIN_MAX : manual_step;
  // Stage one reduction is clamped so illegal writes cannot exceed six cuts
  assign s1_wr = (avs_writedata[`S1_RED_HI:`S1_RED_LO] > `S1_RED_MAX) ? `S1_RED_MAX : avs_writedata[2:0];

  // Bus handshake: one wait cycle, then the answer with waitrequest low
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data is captured on the first edge and stands with waitrequest low
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      unique case (avs_address)
        `OFS_FILTER_CFG: avs_readdata <= {24'h00_0000, filter_cfg_q};
        `OFS_STAGE1_CFG: avs_readdata <= {24'h00_0000, stage1_cfg_q};
        `OFS_LOOP_CFG: avs_readdata <= {24'h00_0000, loop_cfg_q};
        `OFS_MANUAL_CFG: avs_readdata <= {24'h00_0000, manual_cfg_q};
        `OFS_SQ_TIMER: avs_readdata <= {24'h00_0000, sq_timer_q};
        `OFS_GAIN_STATE: avs_readdata <= {28'h000_0000, gain_state_q};
        `OFS_RSSI: avs_readdata <= {24'h00_0000, rssi_pm_q, rssi_am_q};
        default: avs_readdata <= 32'h0000_0000; // Unmapped and command read as zero
      endcase
    end
  end

  // Software configuration registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      filter_cfg_q <= `RST_FILTER_CFG;
      stage1_cfg_q <= `RST_STAGE1_CFG;
      loop_cfg_q <= `RST_LOOP_CFG;
      manual_cfg_q <= `RST_MANUAL_CFG;
      sq_timer_q <= `RST_SQ_TIMER;
    end else if (wr_take) begin
      if (avs_address == `OFS_FILTER_CFG) begin
        filter_cfg_q <= avs_writedata[7:0];
      end
      if (avs_address == `OFS_STAGE1_CFG) begin
        stage1_cfg_q <= {4'h0, avs_writedata[`S1_BOOST], s1_wr};
      end
      if (avs_address == `OFS_LOOP_CFG) begin
        loop_cfg_q <= {2'b00, avs_writedata[5:0]};
      end
      if (avs_address == `OFS_MANUAL_CFG) begin
        manual_cfg_q <= {4'h0, avs_writedata[3:0]};
      end
      if (avs_address == `OFS_SQ_TIMER) begin
        sq_timer_q <= avs_writedata[7:0];
      end
    end
  end

  // Receive-on edge detector; the input is synchronous already
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_on_q <= 1'b0;
    end else begin
      rx_on_q <= rx_on;
    end
  end

  // AGC window: whole frame or first eight subcarrier pulses
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pulse_cnt_q <= 4'h0;
    end else if (!rx_on) begin
      pulse_cnt_q <= 4'h0;
    end else if (rx_events.subcarrier_pulse && pulse_cnt_q < `AGC_PULSES) begin
      pulse_cnt_q <= pulse_cnt_q + 4'h1;
    end
  end

  assign agc_active = loop_cfg_q[`LC_AGC_EN] && rx_on && rx_on_q &&
                      (!loop_cfg_q[`LC_AGC_MODE] || pulse_cnt_q < `AGC_PULSES);
  // Each comparator edge seen while gain remains costs one step
  assign agc_cut = agc_active && rx_events.agc_edge && step_q < `STEP_MAX;

  // Squelch sequencer: delay after transmit, observe until the mask timer matches
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sq_state_q <= rx_gain_pkg::SQ_IDLE;
      sq_delay_q <= 11'h000;
    end else begin
      unique case (sq_state_q)
        rx_gain_pkg::SQ_IDLE: begin
          if (loop_cfg_q[`LC_SQ_DYN] && rx_events.tx_end) begin
            sq_state_q <= rx_gain_pkg::SQ_DELAY;
            sq_delay_q <= 11'h001;
          end
        end
        rx_gain_pkg::SQ_DELAY: begin
          if (!loop_cfg_q[`LC_SQ_DYN]) begin
            sq_state_q <= rx_gain_pkg::SQ_IDLE;
          end else if (sq_delay_q == 11'(`SQ_DELAY_CYC)) begin
            sq_state_q <= rx_gain_pkg::SQ_OBSERVE;
          end else begin
            sq_delay_q <= sq_delay_q + 11'h001;
          end
        end
        rx_gain_pkg::SQ_OBSERVE: begin
          // Stop once the mask timer reaches the squelch limit or reception starts
          if (!loop_cfg_q[`LC_SQ_DYN] || rx_on || 32'(mask_receive_timer) >= 32'(sq_timer_q)) begin
            sq_state_q <= rx_gain_pkg::SQ_IDLE;
          end
        end
        default: sq_state_q <= rx_gain_pkg::SQ_IDLE;
      endcase
    end
  end

  // Ratio bit picks the main digitizer or the six-times window comparator
  assign sq_edge = loop_cfg_q[`LC_SQ_RATIO] ? rx_events.sq6_edge : rx_events.dig_edge;

  // Transition count over each 50 us observation interval
  always_ff @(posedge clk_sys) begin
    if (!rst_b || sq_state_q != rx_gain_pkg::SQ_OBSERVE) begin
      sq_win_q <= 13'h0000;
      sq_edges_q <= 3'h0;
    end else if (sq_win_q == 13'(SQ_WINDOW_CYC - 1)) begin
      sq_win_q <= 13'h0000;
      sq_edges_q <= 3'h0;
    end else begin
      sq_win_q <= sq_win_q + 13'h0001;
      if (sq_edge && sq_edges_q != 3'h7) begin
        sq_edges_q <= sq_edges_q + 3'h1; // Saturates, only "more than two" matters
      end
    end
  end

  // A cut at interval end when more than two transitions were counted
  assign sq_cut = sq_state_q == rx_gain_pkg::SQ_OBSERVE && sq_win_q == 13'(SQ_WINDOW_CYC - 1) &&
                  sq_edges_q > `SQ_EDGE_LIMIT && sq_step_q < `STEP_MAX;

  // Squelch-acquired step survives receptions until the reset gain command
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sq_step_q <= 4'h0;
    end else if (cmd_reset_gain) begin
      sq_step_q <= manual_step;
    end else if (sq_cut) begin
      sq_step_q <= sq_step_q + 4'h1;
    end
  end

  // Live loop step: AGC during reception, squelch setting otherwise
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      step_q <= 4'h0;
    end else if (cmd_reset_gain) begin
      step_q <= manual_step;
    end else if (!rx_on) begin
      step_q <= sq_cut ? sq_step_q + 4'h1 : sq_step_q;
    end else if (rx_rise) begin
      step_q <= (start_step > sq_step_q) ? start_step : sq_step_q;
    end else if (agc_cut) begin
      step_q <= step_q + 4'h1;
    end
  end

  // Gain state shows the live step and is frozen at the end of each reception
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      gain_state_q <= 4'h0;
    end else if (rx_fall) begin
      gain_state_q <= step_q;
    end else if (rx_on) begin
      gain_state_q <= step_q;
    end
  end

  // Peak hold per channel; cleared by command, receive-on rise or AGC cut, frozen while receive-on low
  always_ff @(posedge clk_sys) begin
    if (!rst_b || clear_signal_strength_command || rx_rise || agc_cut) begin
      rssi_am_q <= 4'h0;
      rssi_pm_q <= 4'h0;
    end else if (rx_on) begin
      if (rssi_am_level > rssi_am_q) begin
        rssi_am_q <= (rssi_am_level > `RSSI_MAX) ? `RSSI_MAX : rssi_am_level;
      end
      if (rssi_pm_level > rssi_pm_q) begin
        rssi_pm_q <= (rssi_pm_level > `RSSI_MAX) ? `RSSI_MAX : rssi_pm_level;
      end
    end
  end

  // Analog settings: step 0..4 widens the window, 5..10 cuts stage two/three gain
  assign eff_step = step_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_ctrl <= '0;
      filter_code_unused <= 1'b0;
    end else begin
      rx_ctrl.lowpass_sel <= filter_cfg_q[`LP_HI:`LP_LO];
      rx_ctrl.first_zero_high_select <= filter_cfg_q[3];
      rx_ctrl.third_zero_mid_select <= filter_cfg_q[2];
      rx_ctrl.third_zero_low_select <= filter_cfg_q[1];
      rx_ctrl.first_zero_lowest_select <= filter_cfg_q[0];
      rx_ctrl.stage1_reduction <= stage1_cfg_q[`S1_RED_HI:`S1_RED_LO];
      rx_ctrl.stage1_boost <= stage1_cfg_q[`S1_BOOST];
      if (eff_step <= `STEP_WIN_MAX) begin
        rx_ctrl.window_step <= eff_step[2:0];
        rx_ctrl.stage23_reduction <= 3'h0;
      end else begin
        rx_ctrl.window_step <= 3'h4;
        rx_ctrl.stage23_reduction <= 3'(eff_step - `STEP_WIN_MAX);
      end
      rx_ctrl.gain_loop_ratio_select <= loop_cfg_q[`LC_AGC_RATIO];
      rx_ctrl.squelch_ratio6 <= loop_cfg_q[`LC_SQ_RATIO];
      // Low-pass 011, 11x and zero codes off the table are flagged, not acted on
      filter_code_unused <= (filter_cfg_q[5:3] == 3'b011) || (filter_cfg_q[5:4] == 2'b11) ||
                            !(filter_cfg_q[3:0] inside {4'h0, 4'h4, 4'h2, 4'h1, 4'h3, 4'h5, 4'h8, 4'hC});
    end
  end

  // Own count of cycles spent in the squelch delay; a long repetition is too costly to unroll
  logic [10:0] sq_dwell_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b || sq_state_q != rx_gain_pkg::SQ_DELAY) begin
      sq_dwell_q <= 11'h000;
    end else begin
      sq_dwell_q <= sq_dwell_q + 11'h001;
    end
  end

  // Checks
  chk_step_bound: assert property (@(posedge clk_sys) disable iff (!rst_b) step_q <= `STEP_MAX)
    else $error("loop step beyond last setting");
  chk_window_gain: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rx_ctrl.stage23_reduction != 3'h0 |-> rx_ctrl.window_step == 3'h4)
    else $error("gain cut before window fully widened");
  chk_s1_reduction: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rx_ctrl.stage1_reduction <= 3'h6)
    else $error("stage one reduction over six steps");
  chk_reset_gain_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cmd_reset_gain |=> step_q == $past(manual_step) && sq_step_q == $past(manual_step))
    else $error("reset gain did not load manual step");
  chk_agc_idle_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !rx_on |=> step_q == $past(sq_cut ? sq_step_q + 4'h1 : sq_step_q) || $past(cmd_reset_gain))
    else $error("AGC state kept while receive-on low");
  chk_gain_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rx_fall |=> gain_state_q == $past(step_q) ##1 ($past(rx_on) || $stable(gain_state_q)))
    else $error("gain state not latched at receive-on fall");
  chk_sq_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sq_state_q == rx_gain_pkg::SQ_DELAY ##1 sq_state_q == rx_gain_pkg::SQ_OBSERVE |->
    sq_dwell_q == 11'(`SQ_DELAY_CYC))
    else $error("squelch started before delay elapsed");
  chk_sq_cut_step: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sq_cut && !cmd_reset_gain |=> sq_step_q == $past(sq_step_q) + 4'h1)
    else $error("squelch cut did not lower gain");
  chk_rssi_cap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rssi_am_q <= `RSSI_MAX && rssi_pm_q <= `RSSI_MAX)
    else $error("RSSI above maximum code");
  chk_rssi_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    clear_signal_strength_command || agc_cut |=> rssi_am_q == 4'h0 && rssi_pm_q == 4'h0)
    else $error("RSSI not restarted");
  chk_rssi_freeze: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !rx_on && !clear_signal_strength_command |=> $stable(rssi_am_q) && $stable(rssi_pm_q))
    else $error("RSSI moved while receive-on low");
  chk_agc_pulses: assert property (@(posedge clk_sys) disable iff (!rst_b)
    loop_cfg_q[`LC_AGC_MODE] && pulse_cnt_q == `AGC_PULSES && rx_on && rx_on_q && !cmd_reset_gain |=>
    step_q == $past(step_q))
    else $error("AGC active after eight pulses");
  chk_agc_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !loop_cfg_q[`LC_AGC_EN] && rx_on && rx_on_q && !cmd_reset_gain |=> step_q == $past(step_q))
    else $error("gain cut with AGC disabled");
  chk_rssi_start: assert property (@(posedge clk_sys) disable iff (!rst_b)
    rx_rise |=> rssi_am_q == 4'h0 && rssi_pm_q == 4'h0)
    else $error("RSSI did not start from zero");

  cov_squelch_cut: cover property (@(posedge clk_sys) disable iff (!rst_b) sq_cut);
  cov_agc_cut: cover property (@(posedge clk_sys) disable iff (!rst_b) agc_cut ##1 agc_cut);
  cov_rx_frame: cover property (@(posedge clk_sys) disable iff (!rst_b) rx_rise ##[1:200] rx_fall);
  cov_bus_write: cover property (@(posedge clk_sys) disable iff (!rst_b) wr_take);
  // Comparator edge arriving after the eight-pulse AGC window has closed
  cov_agc_late: cover property (@(posedge clk_sys) disable iff (!rst_b)
    pulse_cnt_q == `AGC_PULSES && rx_events.agc_edge);

endmodule // rx_gain_squelch_rssi_control

// [rx_gain_params.svh]
// Register offsets, field positions, reset values and timing counts for the receive gain control block
`ifndef RX_GAIN_PARAMS_SVH
`define RX_GAIN_PARAMS_SVH

// Word offsets on the register bus, one address per 32-bit register
`define OFS_FILTER_CFG 4'h0
`define OFS_STAGE1_CFG 4'h1
`define OFS_LOOP_CFG 4'h2
`define OFS_MANUAL_CFG 4'h3
`define OFS_SQ_TIMER 4'h4
`define OFS_GAIN_STATE 4'h5
`define OFS_RSSI 4'h6
`define OFS_COMMAND 4'h7

// Reset values
`define RST_FILTER_CFG 8'h04
`define RST_STAGE1_CFG 8'h06
`define RST_LOOP_CFG 8'h00
`define RST_MANUAL_CFG 8'h00
`define RST_SQ_TIMER 8'h00

// Filter configuration fields (low-pass field shares bit 3 with the zero field)
`define LP_HI 5
`define LP_LO 3
`define ZSEL_HI 3
`define ZSEL_LO 0

// Stage one configuration fields
`define S1_RED_HI 2
`define S1_RED_LO 0
`define S1_BOOST 3
`define S1_RED_MAX 3'h6

// Loop configuration bits
`define LC_AGC_EN 0
`define LC_AGC_MODE 1
`define LC_AGC_ALG 2
`define LC_AGC_RATIO 3
`define LC_SQ_DYN 4
`define LC_SQ_RATIO 5

// Command bits
`define CMD_RESET_GAIN 0
`define CMD_CLEAR_STRENGTH 1

// Loop step figures
`define STEP_MAX 4'hA
`define STEP_WIN_MAX 4'h4
`define SQ_EDGE_LIMIT 3'h2
`define AGC_PULSES 4'h8
`define RSSI_MAX 4'hD

// Timing
`define CLK_PERIOD_NS 10
`define SQ_DELAY_NS 18880
`define SQ_DELAY_CYC ((`SQ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SQ_WINDOW_NS 50000
`define SQ_WINDOW_CYC ((`SQ_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rx_gain_pkg.sv]
// Types shared by the receive gain control block
package rx_gain_pkg;

  // Squelch sequencer states, Gray coded along idle, delay, observe
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_DELAY = 2'b01,
    SQ_OBSERVE = 2'b11
  } sq_state_t;

  // Settings driven into the analog receive chain
  typedef struct packed {
    logic [2:0] lowpass_sel;
    logic first_zero_high_select;
    logic third_zero_mid_select;
    logic third_zero_low_select;
    logic first_zero_lowest_select;
    logic [2:0] stage1_reduction;
    logic stage1_boost;
    logic [2:0] stage23_reduction;
    logic [2:0] window_step;
    logic gain_loop_ratio_select;
    logic squelch_ratio6;
  } rx_ctrl_t;

  // Events reported by the analog chain and framing logic
  typedef struct packed {
    logic tx_end;
    logic dig_edge;
    logic sq6_edge;
    logic agc_edge;
    logic subcarrier_pulse;
  } rx_events_t;

endpackage

// [rx_chain_model.sv]
// Behavioural model of the analog receive chain and framing logic
`timescale 1ns/1ps
module rx_chain_model #(
  parameter int MASK_TIMER_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic tx_kick,
  input wire logic rx_en,
  input wire logic agc_kick,
  input wire logic sc_kick,
  input wire logic [1:0] noise,
  output logic rx_on,
  output logic [MASK_TIMER_W-1:0] mask_receive_timer,
  output rx_gain_pkg::rx_events_t rx_events
);
  logic [3:0] pre_q;
  logic [3:0] gap_q;
  logic mask_q;

  // Mask timer ticks every 16 clocks after transmit ends and stops at its top count
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pre_q <= 4'h0;
      mask_receive_timer <= '0;
      mask_q <= 1'h0;
    end else if (tx_kick) begin
      pre_q <= 4'h0;
      mask_receive_timer <= '0;
      mask_q <= 1'h1;
    end else if (mask_q) begin
      pre_q <= pre_q + 4'h1;
      if (pre_q == 4'hF) begin
        mask_receive_timer <= mask_receive_timer + 1'b1;
      end
      if (&mask_receive_timer) begin
        mask_q <= 1'h0;
      end
    end
  end

  // Receive-on stays low while the mask runs, whatever the host asks
  always_ff @(posedge clk_sys) begin
    rx_on <= rst_b && rx_en && !mask_q && !tx_kick;
  end

  // Noise source: one edge every ten clocks, so five per squelch interval
  always_ff @(posedge clk_sys) begin
    gap_q <= (!rst_b || gap_q == 4'h9) ? 4'h0 : gap_q + 4'h1;
  end

  // One-cycle event pulses towards the block
  always_ff @(posedge clk_sys) begin
    rx_events.tx_end <= tx_kick;
    rx_events.dig_edge <= noise[0] && gap_q == 4'h0;
    rx_events.sq6_edge <= noise[1] && gap_q == 4'h0;
    rx_events.agc_edge <= agc_kick;
    rx_events.subcarrier_pulse <= sc_kick;
  end
endmodule // rx_chain_model

// [rx_gain_squelch_rssi_control_bench.sv]
// Self-checking bench for the receive gain control block
`timescale 1ns/1ps
module rx_gain_squelch_rssi_control_bench;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_on;
  logic [7:0] mask_tmr;
  rx_gain_pkg::rx_events_t ev;
  rx_gain_pkg::rx_ctrl_t ctl;
  rx_gain_pkg::rx_ctrl_t ectl;
  logic unused_code;
  logic [3:0] am = 4'h0;
  logic [3:0] pm = 4'h0;
  logic tx_kick = 1'h0;
  logic rx_en = 1'h0;
  logic agc_kick = 1'h0;
  logic sc_kick = 1'h0;
  logic [1:0] noise = 2'h0;
  logic [31:0] q;
  logic [7:0] rst_tab [9] = '{8'h04, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [19:0] rb_tab [5] = '{20'h2_3F3F, 20'h3_0707, 20'h4_8484, 20'h5_5500, 20'h9_FF00};
  logic [8:0] flt_tab [6] = '{9'h004, 9'h118, 9'h020, 9'h107, 9'h02C, 9'h010};
  logic [23:0] sq_tab [6] = '{24'h00_1C81, 24'h10_2C81, 24'h10_1C8A, 24'h30_1C81, 24'h30_2C8A, 24'h10_1845};
  int n_mismatch = 0;
  int tests_run = 0;

  // Free-running 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  rx_chain_model #(.MASK_TIMER_W(8)) far (
    .clk_sys(clk_sys), .rst_b(rst_b), .tx_kick(tx_kick), .rx_en(rx_en), .agc_kick(agc_kick),
    .sc_kick(sc_kick), .noise(noise), .rx_on(rx_on), .mask_receive_timer(mask_tmr), .rx_events(ev));

  rx_gain_squelch_rssi_control #(.SQ_WINDOW_CYC(50), .MASK_TIMER_W(8)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_on(rx_on), .mask_receive_timer(mask_tmr), .rx_events(ev),
    .rssi_am_level(am), .rssi_pm_level(pm), .rx_ctrl(ctl), .filter_code_unused(unused_code));

  // Closing report, reached from the main sequence or a bus timeout
  task automatic wrap_up();
    $display("Counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // One bus access; request held until waitrequest is seen low, then released
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      wrap_up();
    end
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk_sys);
  endtask

  // Spaced one-cycle gain-loop comparator pulse
  task automatic kick_agc();
    agc_kick <= 1'h1;
    cyc(1);
    agc_kick <= 1'h0;
    cyc(5);
  endtask

  // Expected window and stage two/three settings for a loop step
  function automatic logic [5:0] gw(input int s);
    return (s > 4) ? {3'h4, 3'(s - 4)} : {3'(s), 3'h0};
  endfunction

  initial begin
    cyc(16);
    rst_b <= 1'h1;
    cyc(3);
    ectl = '0;
    ectl.third_zero_mid_select = 1'h1;
    ectl.stage1_reduction = 3'h6;
    chk("ctrl_reset", ctl, ectl);
    for (int i = 0; i < 9; i++) begin
      acc(1'h0, 4'(i), 8'h00);
      chk("reg_reset", q, {24'h00_0000, rst_tab[i]});
    end
    // Writable registers read back, read-only and unmapped places do not take writes
    foreach (rb_tab[i]) begin
      acc(1'h1, rb_tab[i][19:16], rb_tab[i][15:8]);
      acc(1'h0, rb_tab[i][19:16], 8'h00);
      chk("readback", q, {24'h00_0000, rb_tab[i][7:0]});
    end
    cyc(2);
    chk("ratio_bits", {ctl.gain_loop_ratio_select, ctl.squelch_ratio6}, 2'h3);
    $display("test registers finished");
    foreach (flt_tab[i]) begin
      acc(1'h1, 4'h0, flt_tab[i][7:0]);
      cyc(2);
      chk("unused_code", unused_code, flt_tab[i][8]);
      chk("filter_bits", {ctl.lowpass_sel, ctl.first_zero_high_select, ctl.third_zero_mid_select,
        ctl.third_zero_low_select, ctl.first_zero_lowest_select}, {flt_tab[i][5:3], flt_tab[i][3:0]});
    end
    acc(1'h1, 4'h1, 8'h0F);
    cyc(2);
    chk("stage1", {ctl.stage1_boost, ctl.stage1_reduction}, 4'hE);
    acc(1'h1, 4'h1, 8'h02);
    cyc(2);
    chk("stage1", {ctl.stage1_boost, ctl.stage1_reduction}, 4'h2);
    $display("test filter and stage one finished");
    // Squelch runs: loop bits, noise source, squelch timer and the step expected at the end
    foreach (sq_tab[i]) begin
      acc(1'h1, 4'h3, 8'h01);
      acc(1'h1, 4'h4, sq_tab[i][11:4]);
      acc(1'h1, 4'h2, sq_tab[i][23:16]);
      acc(1'h1, 4'h7, 8'h01);
      cyc(3);
      chk("gain_start", {ctl.window_step, ctl.stage23_reduction}, gw(1));
      noise <= sq_tab[i][13:12];
      tx_kick <= 1'h1;
      cyc(1);
      tx_kick <= 1'h0;
      cyc(4400);
      noise <= 2'h0;
      cyc(3);
      chk("squelch_step", {ctl.window_step, ctl.stage23_reduction}, gw(int'(sq_tab[i][3:0])));
    end
    $display("test squelch finished");
    acc(1'h1, 4'h3, 8'h00);
    acc(1'h1, 4'h2, 8'h01);
    acc(1'h1, 4'h7, 8'h01);
    am <= 4'h9;
    pm <= 4'h5;
    rx_en <= 1'h1;
    cyc(8);
    repeat (3) kick_agc();
    chk("agc_cut", {ctl.window_step, ctl.stage23_reduction}, gw(3));
    acc(1'h0, 4'h6, 8'h00);
    chk("rssi", q, 32'h0000_0059);
    am <= 4'h3;
    cyc(4);
    acc(1'h0, 4'h6, 8'h00);
    chk("rssi_hold", q, 32'h0000_0059);
    am <= 4'hF;
    cyc(4);
    acc(1'h0, 4'h6, 8'h00);
    chk("rssi_cap", q, 32'h0000_005D);
    rx_en <= 1'h0;
    cyc(6);
    acc(1'h0, 4'h5, 8'h00);
    chk("gain_latch", q, 32'h0000_0003);
    pm <= 4'hF;
    cyc(4);
    acc(1'h0, 4'h6, 8'h00);
    chk("rssi_frozen", q, 32'h0000_005D);
    acc(1'h1, 4'h7, 8'h02);
    cyc(2);
    acc(1'h0, 4'h6, 8'h00);
    chk("rssi_clear", q, 32'h0000_0000);
    $display("test agc and rssi finished");
    acc(1'h1, 4'h2, 8'h03);
    rx_en <= 1'h1;
    cyc(8);
    kick_agc();
    chk("agc_early", {ctl.window_step, ctl.stage23_reduction}, gw(1));
    repeat (8) begin
      sc_kick <= 1'h1;
      cyc(1);
      sc_kick <= 1'h0;
      cyc(2);
    end
    kick_agc();
    chk("agc_late", {ctl.window_step, ctl.stage23_reduction}, gw(1));
    rx_en <= 1'h0;
    cyc(6);
    acc(1'h1, 4'h2, 8'h05);
    rx_en <= 1'h1;
    cyc(8);
    chk("agc_preset", {ctl.window_step, ctl.stage23_reduction}, gw(4));
    kick_agc();
    chk("preset_cut", {ctl.window_step, ctl.stage23_reduction}, gw(5));
    rx_en <= 1'h0;
    cyc(6);
    acc(1'h1, 4'h2, 8'h00);
    rx_en <= 1'h1;
    cyc(8);
    kick_agc();
    chk("agc_off", {ctl.window_step, ctl.stage23_reduction}, gw(0));
    rx_en <= 1'h0;
    cyc(4);
    $display("test agc modes finished");
    wrap_up();
  end
endmodule // rx_gain_squelch_rssi_control_bench
